/* pkg/fps_pkg.sv */
// constants and types shared by the flash command sequencer files
// assumes one 20 mhz clock and parameter words loaded by local logic
package fps_pkg;

  // ************************************
  // command codes and index values
  // ************************************
  localparam logic [7:0] CMD_PROG_PF   = 8'h06; // program one p-flash phrase
  localparam logic [7:0] CMD_PROG_ONCE = 8'h07; // one-time phrase program
  localparam logic [7:0] CMD_ERASE_BLK = 8'h09; // erase whole block
  localparam logic [7:0] CMD_ERASE_SEC = 8'h0a; // erase p-flash sector
  localparam logic [2:0] IDX_LAST_DATA = 3'h5;  // index after four data words
  localparam logic [2:0] IDX_ADDR_LO   = 3'h1;  // index of low address word
  localparam int         NUM_WORDS     = 6;     // parameter words held

  // ************************************
  // field positions
  // ************************************
  localparam int CMD_HI   = 15; // command code in word 0
  localparam int CMD_LO   = 8;
  localparam int BLK_HI   = 6;  // address bits 22..16 in word 0
  localparam int ADDR_W   = 23; // global address width
  localparam int PH_LSB_W = 3;  // phrase offset bits
  localparam int BLK_LSB  = 16; // first block-select address bit

  // ************************************
  // one-time field and protection
  // ************************************
  localparam logic [15:0] ONCE_MAX_IDX = 16'h0007; // last one-time phrase
  localparam int          ONCE_PHRASES = 8;        // 64 bytes as 8 phrases
  localparam logic [ADDR_W-1:0] PROT_TOP  = 23'h7f_ffff; // region top
  localparam logic [ADDR_W-1:0] PROT_MIN  = 23'h00_0800; // 2 kbytes at code 0
  localparam logic [1:0]  PROT_SIZE_RST = 2'h3;    // reset size code
  localparam logic        PROT_DIS_RST  = 1'b1;    // range disabled at reset

  // ************************************
  // types
  // ************************************
  typedef logic [NUM_WORDS-1:0][15:0] fps_words_t; // parameter word bank
  typedef enum logic [2:0] {
    OP_BLANK,  // check a phrase is erased
    OP_PROG,   // program one phrase
    OP_ERASE_B,// erase a block
    OP_ERASE_S,// erase a sector
    OP_VERIFY  // read back and check
  } fps_op_e;
  typedef enum logic [2:0] {
    ST_IDLE, ST_CHECK, ST_BLANK, ST_PROG, ST_ERASE, ST_VERIFY, ST_DONE
  } fps_state_e;

endpackage

/* verilog/fps_param_bank.sv */
// parameter word bank with its load index
// assumes writes come from logic on the same clock
`timescale 1ns/1ns
`default_nettype none
module fps_param_bank
  import fps_pkg::*;
(
  input  wire logic             clk,       // system clock
  input  wire logic             rst_n,     // sync reset, low
  input  wire logic             ce,        // clock enable
  input  wire logic             accept,    // writes allowed now
  input  wire logic             wr_en,     // load one word
  input  wire logic [2:0]       wr_index,  // index of the word
  input  wire logic [15:0]      wr_data,   // word value
  output var  logic [2:0]       param_index, // last index loaded
  output var  fps_words_t       command_param_words // all words
);

  // ************************************
  // storage
  // ************************************
  logic [15:0] mem_r [NUM_WORDS];   // word array
  logic [2:0]  idx_r;               // index register
  wire         take = wr_en && accept && (wr_index < 3'(NUM_WORDS));

  // index follows each accepted write; busy writes dropped
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      idx_r <= '0;
    else if (ce && take)
      idx_r <= wr_index;
  end

  // one generate lane per word keeps the array write trivial
  for (genvar g = 0; g < NUM_WORDS; g++)
  begin : g_word
    always_ff @(posedge clk)
    begin
      if (!rst_n)
        mem_r[g] <= '0;
      else if (ce && take && (wr_index == 3'(g)))
        mem_r[g] <= wr_data;
    end
    assign command_param_words[g] = mem_r[g];
  end

  assign param_index = idx_r;

endmodule
`default_nettype wire

/* verilog/fps_prot_check.sv */
// upper protection range compare
// assumes size and disable come from registers in the parent
`timescale 1ns/1ns
`default_nettype none
module fps_prot_check
  import fps_pkg::*;
(
  input  wire logic [ADDR_W-1:0] addr,     // address under test
  input  wire logic [1:0]        size,     // upper_protect_size
  input  wire logic              disable_r,// upper_range_disable
  output var  logic              addr_prot,// address inside region
  output var  logic              blk_prot  // block holds the region
);

  // ************************************
  // region bounds
  // ************************************
  // region is 2k shifted by the code, so always 2k aligned
  wire [ADDR_W-1:0] span = ADDR_W'(PROT_MIN << size);
  wire [ADDR_W-1:0] low  = ADDR_W'(PROT_TOP - span + 23'h1);
  // region never crosses a 64k block, so top block alone holds it
  wire              top_blk = addr[ADDR_W-1:BLK_LSB] == PROT_TOP[ADDR_W-1:BLK_LSB];

  assign addr_prot = !disable_r && (addr >= low);
  assign blk_prot  = !disable_r && top_blk;

endmodule
`default_nettype wire

/* verilog/fps_sequencer.sv */
// flash command sequencer: launch checks, operation steps, status
// assumes a flash engine on the same clock answering with eng_done
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - size code picks 2, 4, 8, 16k top region
// - phrase program needs index 101 at launch
// - command refused when mode forbids it
// - program address must map to valid flash
// - program address must be phrase aligned
// - program into protected region flags violation
// - verify sets any-error and uncorrectable bits
// - one-time phrase index only 0 to 7
// - one-time field is 8 phrases, block 0
// - one-time: blank check, program, then verify
// - complete flag low until command finishes
// - second one-time program of phrase refused
// - block 0 reads invalid during one-time program
// - block erase erases, verifies, then completes
// - block erase needs index 001 at launch
// - block erase needs valid block select bits
// - block erase alignment: phrase p-flash, word d-flash
// - block erase of protected block flags violation
// - sector erase erases, verifies, then completes
// - size code writable only while range disabled
module fps_sequencer
  import fps_pkg::*;
#(
  parameter logic [6:0]  PF_LO_BLK = 7'h7e, // lowest p-flash block
  parameter logic [6:0]  DF_LO_BLK = 7'h10, // lowest d-flash block
  parameter logic [6:0]  DF_HI_BLK = 7'h10, // highest d-flash block
  parameter logic [6:0]  PF0_BLK   = 7'h7f  // block holding one-time row
)
(
  input  wire logic              clk,            // 20 mhz clock
  input  wire logic              rst_n,          // sync reset, low
  input  wire logic              ce,             // clock enable
  input  wire logic              wr_en,          // load parameter word
  input  wire logic [2:0]        wr_index,       // word index
  input  wire logic [15:0]       wr_data,        // word value
  input  wire logic              launch,         // clear complete flag
  input  wire logic              err_clear,      // clear both error flags
  input  wire logic              cmd_permitted,  // mode/security allow
  input  wire logic              prot_wr,        // protection write
  input  wire logic [1:0]        prot_wr_size,   // new size code
  input  wire logic              prot_wr_dis,    // new disable bit
  input  wire logic [ADDR_W-1:0] rd_addr,        // current flash read
  input  wire logic              eng_done,       // engine step finished
  input  wire logic              eng_fail,       // blank check not erased
  input  wire logic              eng_err,        // verify saw an error
  input  wire logic              eng_uncorr,     // verify uncorrectable
  output logic                   command_complete_flag,
  output logic                   access_error_flag,
  output logic                   protection_violation_flag,
  output logic                   verify_any_error_bit,
  output logic                   verify_uncorrectable_bit,
  output logic [1:0]             upper_protect_size,
  output logic                   upper_range_disable,
  output logic                   rd_invalid,     // read data not valid
  output logic                   eng_start,      // engine step pulse
  output fps_op_e                eng_op,         // engine step kind
  output logic [ADDR_W-1:0]      eng_addr,       // step address
  output logic                   eng_info,       // targets one-time row
  output logic [63:0]            eng_data        // phrase to program
);

  // ************************************
  // elaboration checks
  // ************************************
  if (DF_LO_BLK > DF_HI_BLK || DF_HI_BLK >= PF_LO_BLK)
  begin : g_bad_map
    $error("fps_sequencer: flash block map overlaps");
  end

  // ************************************
  // state
  // ************************************
  fps_state_e state_r, state_nxt;   // sequencer state
  logic  cc_r, acc_r, fpv_r;        // complete, access, violation
  logic  mg1_r, mg0_r;              // verify status bits
  logic [1:0] size_r;               // protection size code
  logic  dis_r;                     // protection range disable
  logic  wait_r;                    // engine step outstanding
  logic  rdinv_r;                   // read invalid flop
  logic  start_r, info_r;           // engine controls
  fps_op_e op_r;                    // engine step kind
  logic [ADDR_W-1:0] addr_r;        // engine address
  logic [63:0] data_r;              // engine data
  logic [7:0]  cmd_r;               // command held while running

  // ************************************
  // parameter bank and decode
  // ************************************
  fps_words_t words;                // loaded words
  logic [2:0] idx;                  // param_index
  // writes only count while idle, so words stay put while running
  fps_param_bank u_bank (
    .clk                 (clk),
    .rst_n               (rst_n),
    .ce                  (ce),
    .accept              (cc_r),
    .wr_en               (wr_en),
    .wr_index            (wr_index),
    .wr_data             (wr_data),
    .param_index         (idx),
    .command_param_words (words)
  );

  wire [7:0]        cmd   = words[0][CMD_HI:CMD_LO];
  wire [6:0]        blk   = words[0][BLK_HI:0];
  wire [ADDR_W-1:0] gaddr = {blk, words[1]};
  wire [15:0]       ph_ix = words[1];
  wire              is_pf = blk >= PF_LO_BLK;
  wire              is_df = (blk >= DF_LO_BLK) && (blk <= DF_HI_BLK);
  wire              al_ph = gaddr[PH_LSB_W-1:0] == '0;
  wire              al_w  = !gaddr[0];

  logic addr_prot, blk_prot;        // protection compare
  fps_prot_check u_prot (
    .addr      (gaddr),
    .size      (size_r),
    .disable_r (dis_r),
    .addr_prot (addr_prot),
    .blk_prot  (blk_prot)
  );

  // ************************************
  // launch checks
  // ************************************
  // program and block erase checks
  wire e_prog  = (idx != IDX_LAST_DATA) || !is_pf || !al_ph;
  wire e_once  = (idx != IDX_LAST_DATA) || (ph_ix > ONCE_MAX_IDX);
  wire e_blk   = (idx != IDX_ADDR_LO) || !(is_pf || is_df) ||
                 (is_pf && !al_ph) || (is_df && !al_w);
  // sector erase is p-flash only
  wire e_sec   = (idx != IDX_ADDR_LO) || !is_pf;
  wire known   = (cmd == CMD_PROG_PF) || (cmd == CMD_PROG_ONCE) ||
                 (cmd == CMD_ERASE_BLK) || (cmd == CMD_ERASE_SEC);
  wire acc_chk = !cmd_permitted || !known ||
                 ((cmd == CMD_PROG_PF) && e_prog) ||
                 ((cmd == CMD_PROG_ONCE) && e_once) ||
                 ((cmd == CMD_ERASE_BLK) && e_blk) ||
                 ((cmd == CMD_ERASE_SEC) && e_sec);
  wire fpv_chk = ((cmd == CMD_PROG_PF) && addr_prot) ||
                 ((cmd == CMD_ERASE_SEC) && addr_prot) ||
                 ((cmd == CMD_ERASE_BLK) && is_pf && blk_prot);
  wire chk_fail = acc_chk || fpv_chk;

  // launch ignored while busy or an error flag still stands
  wire launch_ok = launch && cc_r && !acc_r && !fpv_r;
  wire step_done = wait_r && eng_done;
  wire in_check  = state_r == ST_CHECK;
  wire once_run  = (cmd_r == CMD_PROG_ONCE) && (state_r != ST_IDLE);
  wire [ADDR_W-1:0] once_addr = ADDR_W'({ph_ix[2:0], 3'h0});
  wire blank_bad = (state_r == ST_BLANK) && step_done && eng_fail;

  // ************************************
  // next state
  // ************************************
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (launch_ok)
          state_nxt = ST_CHECK;
      // failed check skips straight to done
      ST_CHECK:
        if (chk_fail)
          state_nxt = ST_DONE;
        else if (cmd == CMD_PROG_ONCE)
          state_nxt = ST_BLANK;
        else if (cmd == CMD_PROG_PF)
          state_nxt = ST_PROG;
        else
          state_nxt = ST_ERASE;
      ST_BLANK:
        if (step_done)
          state_nxt = eng_fail ? ST_DONE : ST_PROG;
      ST_PROG, ST_ERASE:
        if (step_done)
          state_nxt = ST_VERIFY;
      ST_VERIFY:
        if (step_done)
          state_nxt = ST_DONE;
      ST_DONE:
        state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state_r <= ST_IDLE;
    else if (ce)
      state_r <= state_nxt;
  end

  // command latched so decode of words is not relied on later
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cmd_r <= '0;
    else if (ce && launch_ok)
      cmd_r <= cmd;
  end

  // ************************************
  // status flags
  // ************************************
  // complete flag low while running
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cc_r <= 1'b1;
    else if (ce)
      cc_r <= (state_r == ST_DONE) ? 1'b1 : (launch_ok ? 1'b0 : cc_r);
  end

  // error flags: a set in the clear cycle wins
  wire acc_set = (in_check && acc_chk) || blank_bad;
  wire fpv_set = in_check && !acc_chk && fpv_chk;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      acc_r <= 1'b0;
      fpv_r <= 1'b0;
    end
    else if (ce)
    begin
      acc_r <= acc_set || (acc_r && !err_clear);
      fpv_r <= fpv_set || (fpv_r && !err_clear);
    end
  end

  // verify outcome captured, cleared at next launch
  wire vfy_end = (state_r == ST_VERIFY) && step_done;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mg1_r <= 1'b0;
      mg0_r <= 1'b0;
    end
    else if (ce && vfy_end)
    begin
      mg1_r <= eng_err;
      mg0_r <= eng_uncorr;
    end
    else if (ce && launch_ok)
    begin
      mg1_r <= 1'b0;
      mg0_r <= 1'b0;
    end
  end

  // size code held unless range currently disabled
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      size_r <= PROT_SIZE_RST;
      dis_r  <= PROT_DIS_RST;
    end
    else if (ce && prot_wr)
    begin
      dis_r <= prot_wr_dis;
      if (dis_r)
        size_r <= prot_wr_size;
    end
  end

  // ************************************
  // engine requests
  // ************************************
  wire op_state = (state_r == ST_BLANK) || (state_r == ST_PROG) ||
                  (state_r == ST_ERASE) || (state_r == ST_VERIFY);
  wire issue    = op_state && !wait_r && !start_r;
  fps_op_e op_sel;                  // step kind for this state
  assign op_sel = (state_r == ST_BLANK)  ? OP_BLANK :
                  (state_r == ST_PROG)   ? OP_PROG :
                  (state_r == ST_VERIFY) ? OP_VERIFY :
                  (cmd_r == CMD_ERASE_SEC) ? OP_ERASE_S : OP_ERASE_B;

  // one start pulse per step, then wait for done
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      start_r <= 1'b0;
      wait_r  <= 1'b0;
    end
    else if (ce)
    begin
      start_r <= issue;
      wait_r  <= start_r ? 1'b1 : (eng_done ? 1'b0 : wait_r);
    end
  end

  // step kind, address and data set with the pulse
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      op_r   <= OP_BLANK;
      addr_r <= '0;
      info_r <= 1'b0;
      data_r <= '0;
    end
    else if (ce && issue)
    begin
      op_r   <= op_sel;
      addr_r <= (cmd_r == CMD_PROG_ONCE) ? once_addr : gaddr;
      info_r <= cmd_r == CMD_PROG_ONCE;
      data_r <= {words[5], words[4], words[3], words[2]};
    end
  end

  // block 0 reads flagged while one-time runs
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdinv_r <= 1'b0;
    else if (ce)
      rdinv_r <= once_run && (rd_addr[ADDR_W-1:BLK_LSB] == PF0_BLK);
  end

  // ************************************
  // outputs
  // ************************************
  assign command_complete_flag     = cc_r;
  assign access_error_flag         = acc_r;
  assign protection_violation_flag = fpv_r;
  assign verify_any_error_bit      = mg1_r;
  assign verify_uncorrectable_bit  = mg0_r;
  assign upper_protect_size        = size_r;
  assign upper_range_disable       = dis_r;
  assign rd_invalid                = rdinv_r;
  assign eng_start                 = start_r;
  assign eng_op                    = op_r;
  assign eng_addr                  = addr_r;
  assign eng_info                  = info_r;
  assign eng_data                  = data_r;

  // ************************************
  // assertions
  // ************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !ce);

  sequence s_reject;
    in_check && chk_fail ##1 state_r == ST_DONE ##1 cc_r && !start_r;
  endsequence

  a_cc_low_run: assert property (launch_ok |=> !cc_r [*2])
    else $error("complete flag not low after launch");
  a_cc_set_done: assert property ($rose(cc_r) |-> $past(state_r) == ST_DONE)
    else $error("complete flag set outside done");
  a_prog_idx_err: assert property (launch_ok && cmd == CMD_PROG_PF && idx != IDX_LAST_DATA
    |-> ##2 acc_r)
    else $error("program index error not flagged");
  a_mode_err: assert property (launch_ok && !cmd_permitted |-> ##2 acc_r)
    else $error("forbidden command not flagged");
  a_once_range: assert property (launch_ok && cmd == CMD_PROG_ONCE && ph_ix > ONCE_MAX_IDX
    |-> ##2 acc_r)
    else $error("one-time index out of range not flagged");
  a_prog_prot: assert property (launch_ok && cmd == CMD_PROG_PF && !e_prog
    && cmd_permitted && addr_prot |-> ##2 fpv_r && !acc_r)
    else $error("protected program not flagged");
  a_reject_fast: assert property (in_check && chk_fail |-> s_reject)
    else $error("failed launch did not complete promptly");
  a_blank_first: assert property (start_r && op_r == OP_PROG && info_r
    |-> $past(state_r, 2) == ST_BLANK)
    else $error("one-time program without blank check");
  a_size_locked: assert property (!dis_r |=> $stable(size_r))
    else $error("size changed while range enabled");
  a_verify_bits: assert property (vfy_end |=> mg1_r == $past(eng_err)
    && mg0_r == $past(eng_uncorr))
    else $error("verify bits not captured");

endmodule
`default_nettype wire

/* tb/fps_sequencer_tb.sv */
// self-checking bench for the flash command sequencer
// assumes fps_pkg is compiled first; the bench plays software and engine
`timescale 1ns/1ns
`default_nettype none
module fps_sequencer_tb;
  import fps_pkg::*;
  // ************************************
  // signals
  // ************************************
  localparam logic [6:0] B0 = 7'h7f; // block holding one-time row
  logic clk = 0, rst_n = 0, ce = 1, wr_en = 0, launch = 0, err_clear = 0;
  logic cmd_permitted = 1, prot_wr = 0, prot_wr_dis = 0, eng_done = 0;
  logic eng_fail = 0, eng_err = 0, eng_uncorr = 0;
  logic [1:0]        prot_wr_size = 0;
  logic [2:0]        wr_index = 0;
  logic [15:0]       wr_data = 0;
  logic [ADDR_W-1:0] rd_addr = 0, eng_addr, xaddr;
  logic command_complete_flag, access_error_flag, protection_violation_flag;
  logic verify_any_error_bit, verify_uncorrectable_bit, upper_range_disable;
  logic rd_invalid, eng_start, eng_info, xi;
  logic [1:0]        upper_protect_size;
  fps_op_e           eng_op;
  logic [63:0]       eng_data;
  logic [15:0]       w [6];  // words software loads
  logic [2:0]        ph;     // one-time phrase
  int                fails = 0, total_checks = 0;
  fps_sequencer #(.PF0_BLK(B0)) u_fps_sequencer
  (
    .clk, .rst_n, .ce, .wr_en, .wr_index, .wr_data, .launch, .err_clear,
    .cmd_permitted, .prot_wr, .prot_wr_size, .prot_wr_dis, .rd_addr,
    .eng_done, .eng_fail, .eng_err, .eng_uncorr, .command_complete_flag,
    .access_error_flag, .protection_violation_flag, .verify_any_error_bit,
    .verify_uncorrectable_bit, .upper_protect_size, .upper_range_disable,
    .rd_invalid, .eng_start, .eng_op, .eng_addr, .eng_info, .eng_data
  );
  initial forever #25 clk = ~clk;
  // ************************************
  // helpers
  // ************************************
  // first protected address for a size code
  function automatic logic [ADDR_W-1:0] plo(logic [1:0] s);
    return 23'h7f_ffff - (23'h00_0800 << s) + 23'h1;
  endfunction
  task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // inputs always change 5 ns after the rising edge
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task automatic prot(logic [1:0] s, logic d);
    prot_wr = 1; prot_wr_size = s; prot_wr_dis = d;
    tick();
    prot_wr = 0;
    // let an edge pass so back-to-back writes never re-raise the strobe at once
    tick();
  endtask
  // launch and play the engine; done comes 3 cycles after each start
  task automatic cmd(logic [7:0] c, logic [ADDR_W-1:0] a, int last, logic bf,
                     logic [4:0] xm, logic xa, logic xv);
    logic [4:0] m;
    logic [1:0] e, ve;
    fps_op_e    op;
    int         d, n;
    // code, address, data at their indices
    w[0] = {c, 1'b0, a[22:16]};
    w[1] = a[15:0];
    for (int i = 2; i < 6; i++) w[i] = 16'($urandom);
    for (int i = 0; i <= last; i++)
    begin
      wr_en = 1; wr_index = 3'(i); wr_data = w[i];
      tick();
    end
    wr_en = 0; m = 0; d = 0;
    e = 2'($urandom);
    ve = {e[0] | e[1], e[1]}; // uncorrectable implies any error
    launch = 1;
    tick();
    launch = 0;
    for (n = 0; n < 300; n++)
    begin
      tick();
      eng_done = (d == 1);
      eng_fail = (d == 1) && bf && op == OP_BLANK;
      {eng_err, eng_uncorr} = (d == 1 && op == OP_VERIFY) ? ve : 2'h0;
      if (d > 0) d--;
      if (n == 0) chk("cc_low", command_complete_flag, 1'b0);
      if (eng_start === 1'b1)
      begin
        op = eng_op; m[op] = 1'b1; d = 3;
        chk("rd_invalid", rd_invalid, xi);
        if (op == OP_PROG) chk("eng_data", eng_data, {w[5], w[4], w[3], w[2]});
        if (xi || op == OP_PROG) chk("eng_addr", {eng_info, eng_addr}, {xi, xaddr});
      end
      if (n >= 2 && d == 0 && command_complete_flag === 1'b1) break;
    end
    if (n == 300)
    begin
      fails++;
      conclude();
    end
    chk("ops", m, xm);
    chk("acc", access_error_flag, xa);
    chk("vio", protection_violation_flag, xv);
    chk("mg", {verify_any_error_bit, verify_uncorrectable_bit}, xm[4] ? ve : 2'h0);
    if (xm == 0) chk("quick", n < 4, 1'b1);
    err_clear = 1;
    tick();
    err_clear = 0;
  endtask
  // ************************************
  // main sequence
  // ************************************
  initial
  begin
    void'($urandom(32));
    tick(2);
    rst_n = 1;
    chk("reset", {command_complete_flag, access_error_flag, upper_protect_size,
        upper_range_disable}, {1'b1, 1'b0, 2'h3, 1'b1});
    // size follows only while range disabled
    prot(2'h1, 1'b1);
    prot(2'h2, 1'b0);
    prot(2'h0, 1'b0);
    chk("size", {upper_protect_size, upper_range_disable}, {2'h2, 1'b0});
    xi = 0;
    rd_addr = {B0, 16'h0};
    // each size code: first protected address and the phrase just below
    for (int s = 0; s < 4; s++)
    begin
      prot(2'(s), 1'b1);
      prot(2'(s), 1'b0);
      xaddr = plo(2'(s));
      cmd(CMD_PROG_PF, xaddr, 5, 0, 5'h00, 0, 1);
      xaddr = xaddr - 23'h8;
      cmd(CMD_PROG_PF, xaddr, 5, 0, 5'h12, 0, 0);
    end
    cmd(CMD_PROG_PF, xaddr, 4, 0, 5'h00, 1, 0);
    cmd(CMD_PROG_PF, xaddr | 23'h3, 5, 0, 5'h00, 1, 0);
    cmd(CMD_PROG_PF, {7'h20, 16'h0}, 5, 0, 5'h00, 1, 0);
    cmd(8'h33, xaddr, 5, 0, 5'h00, 1, 0);
    // block erase: protected, valid, bad block, misaligned, wrong index
    cmd(CMD_ERASE_BLK, {B0, 16'h0}, 1, 0, 5'h00, 0, 1);
    cmd(CMD_ERASE_BLK, {7'h7e, 16'h0}, 1, 0, 5'h14, 0, 0);
    cmd(CMD_ERASE_BLK, {7'h20, 16'h0}, 1, 0, 5'h00, 1, 0);
    cmd(CMD_ERASE_BLK, {7'h7e, 16'h3}, 1, 0, 5'h00, 1, 0);
    cmd(CMD_ERASE_BLK, {7'h10, 16'h1}, 1, 0, 5'h00, 1, 0);
    cmd(CMD_ERASE_BLK, {7'h10, 16'h2}, 1, 0, 5'h14, 0, 0);
    cmd(CMD_ERASE_BLK, {7'h7e, 16'h0}, 5, 0, 5'h00, 1, 0);
    cmd(CMD_ERASE_SEC, {7'h7e, 16'($urandom)}, 1, 0, 5'h18, 0, 0);
    cmd_permitted = 0;
    cmd(CMD_ERASE_SEC, {7'h7e, 16'h0}, 1, 0, 5'h00, 1, 0);
    cmd_permitted = 1;
    // one-time program, second attempt, phrase out of range
    ph = 3'($urandom);
    xaddr = {17'h0, ph, 3'h0};
    xi = 1;
    cmd(CMD_PROG_ONCE, {20'h0, ph}, 5, 0, 5'h13, 0, 0);
    cmd(CMD_PROG_ONCE, {20'h0, ph}, 5, 1, 5'h01, 1, 0);
    xi = 0;
    cmd(CMD_PROG_ONCE, 23'h8, 5, 0, 5'h00, 1, 0);
    chk("rd_after", rd_invalid, 1'b0);
    // frozen clock enable: a launch held over two edges must leave no trace
    ce = 0;
    launch = 1;
    tick(2);
    launch = 0;
    ce = 1;
    tick();
    chk("ce_hold", {command_complete_flag, access_error_flag}, 2'h2);
    // second reset while idle brings the range back to disabled
    rst_n = 0;
    tick();
    rst_n = 1;
    chk("reset2", {command_complete_flag, upper_protect_size, upper_range_disable},
        {1'b1, 2'h3, 1'b1});
    conclude();
  end
endmodule
`default_nettype wire
